/* File: src/rfp_fault_protect.sv */
// module: regulator fault protection with apb register access
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module rfp_fault_protect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_input,
  input wire logic [2:0] hw_regulator_enable,
  input wire rfp_pkg::rfp_fault_t fault_cond,
  input wire logic monitor_active,
  input wire logic power_up_start,
  input wire rfp_pkg::rfp_otp_t otp_cfg,
  input wire logic [8:0] otp_ignore,
  input wire logic pd_seq_start,
  input wire logic pd_seq_done,
  output logic power_on_gated,
  output logic shutdown_req,
  output logic [2:0] regulator_en,
  output logic [2:0] power_good_out,
  output logic irq_out_n
);
  import rfp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_HOLD} rfp_state_t;

  // synchronisers for pins
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic pon_s;
  logic [2:0] hwen_s;
  logic [8:0] cond_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
    end else begin
      sync1_reg <= {power_on_input, hw_regulator_enable, fault_cond, monitor_active};
      sync2_reg <= sync1_reg;
    end
  end
  assign pon_s = sync2_reg[13];
  assign hwen_s = sync2_reg[12:10];
  assign cond_s = sync2_reg[9:1] & {NCH{sync2_reg[0]}};

  // reference ticks
  logic [4:0] pre_reg;
  logic [9:0] ms_pre_reg;
  logic tick;
  logic ms_tick;
  logic [8:0] prot_active;
  assign tick = (pre_reg == 5'(TICK_CYCLES - 1));
  assign ms_tick = tick && (ms_pre_reg == 10'(MS_US - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 5'h00;
      ms_pre_reg <= 10'h000;
    end else begin
      pre_reg <= tick ? 5'h00 : pre_reg + 5'h01;
      if (prot_active == 9'h000) begin
        ms_pre_reg <= 10'h000;
      end else if (tick) begin
        ms_pre_reg <= (ms_pre_reg == 10'(MS_US - 1)) ? 10'h000 : ms_pre_reg + 10'h001;
      end
    end
  end

  // configuration registers
  logic [1:0] hold_sel_reg;
  logic [3:0] timer_sel_reg;
  logic [3:0] limit_reg;
  logic [8:0] keep_reg;
  logic [2:0] restore_reg;
  logic [8:0] ignore_reg;
  logic [8:0] mask_reg;
  logic [2:0] sw_en_reg;
  logic [8:0] flag_reg;
  logic [3:0] tally_reg;

  logic wr;
  logic rd_setup;
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_sel_reg <= HOLD_RESET;
      timer_sel_reg <= TIMER_RESET;
      limit_reg <= LIMIT_RESET;
      keep_reg <= KEEP_RESET;
      restore_reg <= RESTORE_RESET;
      ignore_reg <= IGNORE_RESET;
      mask_reg <= MASK_RESET;
      sw_en_reg <= ENABLE_RESET;
    end else if (power_up_start) begin
      hold_sel_reg <= otp_cfg.holdoff_sel;
      timer_sel_reg <= otp_cfg.timer_sel;
      limit_reg <= otp_cfg.tally_limit;
      keep_reg <= KEEP_RESET;
      restore_reg <= RESTORE_RESET;
      ignore_reg <= otp_ignore;
      mask_reg <= MASK_RESET;
    end else if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          timer_sel_reg <= pwdata[CTRL_TIMER_LSB +: 4];
          limit_reg <= pwdata[CTRL_LIMIT_LSB +: 4];
        end
        ADDR_KEEP: begin
          keep_reg <= pwdata[8:0];
          restore_reg <= pwdata[KEEP_RESTORE_LSB +: 3];
        end
        ADDR_IGNORE: ignore_reg <= pwdata[8:0];
        ADDR_MASK: mask_reg <= pwdata[8:0];
        ADDR_ENABLE: sw_en_reg <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // per channel debounce, filter and persistence
  logic [8:0] det;
  logic [8:0] trip;
  logic [8:0] det_d_reg;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam bit IS_OC = (gi >= 6);
      localparam logic [10:0] FILT = IS_OC ? 11'(OC_DEBOUNCE_TICKS) : 11'(OVUV_FILTER_TICKS);
      logic [10:0] fcnt_reg;
      logic [8:0] pcnt_reg;
      logic det_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fcnt_reg <= 11'h000;
          det_reg <= 1'b0;
        end else if (cond_s[gi] == det_reg) begin
          fcnt_reg <= 11'h000;
        end else if (tick) begin
          if (fcnt_reg >= FILT - 11'h001) begin
            det_reg <= cond_s[gi];
            fcnt_reg <= 11'h000;
          end else begin
            fcnt_reg <= fcnt_reg + 11'h001;
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pcnt_reg <= 9'h000;
        end else if (!det_reg) begin
          pcnt_reg <= 9'h000;
        end else if (tick && pcnt_reg <= 9'(OVUV_PERSIST_TICKS)) begin
          pcnt_reg <= pcnt_reg + 9'h001;
        end
      end
      assign det[gi] = det_reg;
      // overcurrent trips on acceptance, voltage faults after persisting
      assign trip[gi] = IS_OC ? det_reg : (pcnt_reg > 9'(OVUV_PERSIST_TICKS));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_d_reg <= 9'h000;
    end else begin
      det_d_reg <= det;
    end
  end

  logic [8:0] event_all;
  logic [8:0] prot_event;
  assign event_all = det & ~det_d_reg;
  assign prot_active = det & ~ignore_reg;
  assign prot_event = event_all & ~ignore_reg;

  // fault latches, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 9'h000;
    end else begin
      flag_reg <= (flag_reg & ~((wr && paddr == ADDR_FLAG) ? pwdata[8:0] : 9'h000))
                  | event_all;
    end
  end

  logic irq_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_reg & ~mask_reg);
    end
  end
  assign irq_out_n = !irq_reg;

  // regulator disable and recovery
  logic [2:0] disable_hit;
  logic [2:0] reg_det;
  logic [2:0] request;
  logic [2:0] request_d_reg;
  logic [2:0] fault_off_reg;
  logic [2:0] pg_reg;
  logic [8:0] trip_off;
  assign trip_off = trip & ~ignore_reg & ~keep_reg;
  assign request = sw_en_reg | hwen_s;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      logic [8:0] rcnt_reg;
      logic off_reg;
      assign fault_off_reg[gi] = off_reg;
      assign disable_hit[gi] = trip_off[gi] | trip_off[gi + 3] | trip_off[gi + 6];
      assign reg_det[gi] = det[gi] | det[gi + 3] | det[gi + 6];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rcnt_reg <= 9'h000;
        end else if (!fault_off_reg[gi] || reg_det[gi] || !restore_reg[gi]) begin
          rcnt_reg <= 9'h000;
        end else if (tick && rcnt_reg < 9'(RESTORE_TICKS)) begin
          rcnt_reg <= rcnt_reg + 9'h001;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          off_reg <= 1'b0;
        end else if (disable_hit[gi]) begin
          off_reg <= 1'b1;
        end else if (restore_reg[gi] && rcnt_reg == 9'(RESTORE_TICKS)) begin
          off_reg <= 1'b0;
        end else if (!restore_reg[gi] && request_d_reg[gi] && !request[gi]) begin
          off_reg <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_d_reg <= 3'h0;
      pg_reg <= 3'h0;
    end else begin
      request_d_reg <= request;
      pg_reg <= request & ~fault_off_reg & ~(prot_active[2:0] | prot_active[5:3]);
    end
  end
  assign regulator_en = request & ~fault_off_reg;
  assign power_good_out = pg_reg;

  // shared fault tally
  logic tally_wr;
  logic tally_hit;
  assign tally_wr = wr && paddr == ADDR_TALLY;
  assign tally_hit = (limit_reg != 4'h0) && (tally_reg == limit_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_reg <= 4'h0;
    end else if (|prot_event) begin
      if (tally_reg != limit_reg) begin
        tally_reg <= tally_reg + 4'h1;
      end
    end else if (tally_wr) begin
      tally_reg <= pwdata[3:0];
    end
  end

  // fault timer
  logic [11:0] ftimer_reg;
  logic [11:0] timer_len;
  logic timer_on;
  logic timer_expire;
  always_comb begin
    if (timer_sel_reg == TIMER_LAST_CODE) begin
      timer_len = TIMER_TOP_MS;
    end else begin
      timer_len = 12'h001 << timer_sel_reg;
    end
  end
  assign timer_on = timer_sel_reg <= TIMER_LAST_CODE;
  assign timer_expire = timer_on && (ftimer_reg >= timer_len);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ftimer_reg <= 12'h000;
    end else if (prot_active == 9'h000) begin
      ftimer_reg <= 12'h000;
    end else if (ms_tick && !timer_expire) begin
      ftimer_reg <= ftimer_reg + 12'h001;
    end
  end

  // shutdown request and power-on hold-off
  rfp_state_t state_reg;
  logic [13:0] hcnt_reg;
  logic [13:0] hold_len;
  logic trigger;
  logic trigger_d_reg;
  always_comb begin
    case (hold_sel_reg)
      2'h1: hold_len = 14'(HOLD_1_US / TICK_US);
      2'h2: hold_len = 14'(HOLD_2_US / TICK_US);
      2'h3: hold_len = 14'(HOLD_3_US / TICK_US);
      default: hold_len = 14'h0000;
    endcase
  end
  assign trigger = tally_hit || timer_expire;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_d_reg <= 1'b0;
      shutdown_req <= 1'b0;
    end else begin
      trigger_d_reg <= trigger;
      shutdown_req <= trigger && !trigger_d_reg && state_reg == ST_IDLE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      hcnt_reg <= 14'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          hcnt_reg <= 14'h0000;
          if (pd_seq_start || shutdown_req) begin
            state_reg <= ST_SEQ;
          end
        end
        ST_SEQ: begin
          if (pd_seq_done) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (hcnt_reg >= hold_len) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            hcnt_reg <= hcnt_reg + 14'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign power_on_gated = pon_s && state_reg == ST_IDLE;

  // apb read path
  logic [31:0] rd_next;
  logic [31:0] rd_reg;
  logic mapped;
  always_comb begin
    rd_next = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      ADDR_CTRL: begin
        rd_next[CTRL_HOLD_LSB +: 2] = hold_sel_reg;
        rd_next[CTRL_TIMER_LSB +: 4] = timer_sel_reg;
        rd_next[CTRL_LIMIT_LSB +: 4] = limit_reg;
      end
      ADDR_KEEP: rd_next = {13'h0000, restore_reg, 7'h00, keep_reg};
      ADDR_IGNORE: rd_next = {23'h000000, ignore_reg};
      ADDR_FLAG: rd_next = {23'h000000, flag_reg};
      ADDR_MASK: rd_next = {23'h000000, mask_reg};
      ADDR_STATUS: begin
        rd_next[8:0] = det;
        rd_next[STATUS_EN_LSB +: 3] = regulator_en;
        rd_next[STATUS_STATE_LSB +: 2] = state_reg;
      end
      ADDR_TALLY: rd_next = {28'h0000000, tally_reg};
      ADDR_ENABLE: rd_next = {29'h00000000, sw_en_reg};
      default: mapped = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      rd_reg <= rd_next;
    end
  end
  assign prdata = rd_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // checks
  a_holdoff_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != ST_IDLE) |-> !power_on_gated)
    else $error("power-on passed during hold-off");
  a_hold_length: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_HOLD && hcnt_reg < hold_len) |=> state_reg == ST_HOLD)
    else $error("hold-off ended early");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    ((flag_reg & ~mask_reg) == 9'h000) |=> irq_out_n)
    else $error("interrupt without unmasked latch");
  a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
    ((flag_reg & ~mask_reg) != 9'h000) |=> !irq_out_n)
    else $error("unmasked latch did not assert interrupt");
  a_cfg_reload: assert property (@(posedge pclk) disable iff (!presetn)
    power_up_start |=> keep_reg == KEEP_RESET && restore_reg == RESTORE_RESET)
    else $error("configuration not reloaded");
  a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
    (disable_hit != 3'h0) |=> (regulator_en & $past(disable_hit)) == 3'h0)
    else $error("regulator stayed on after fault");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (event_all != 9'h000) |=> (flag_reg & $past(event_all)) == $past(event_all))
    else $error("fault latch missed event");
  a_tally_step: assert property (@(posedge pclk) disable iff (!presetn)
    (prot_event != 9'h000 && tally_reg != limit_reg) |=> tally_reg == $past(tally_reg) + 4'h1)
    else $error("tally did not step");
  a_limit_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (limit_reg == 4'h0) |-> !tally_hit)
    else $error("zero limit caused shutdown");
  a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (prot_active == 9'h000) |=> ftimer_reg == 12'h000)
    else $error("fault timer ran without protected fault");
  a_timer_off: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_sel_reg > TIMER_LAST_CODE) |-> !timer_expire)
    else $error("disabled timer expired");
endmodule

/* File: src/rfp_pkg.sv */
// package: constants, types and register map of the regulator fault protection block
// Contract
// - power-on input masked from shutdown start until sequence done plus hold-off delay
// - hold-off select 00 none, 01 1.5 ms, 10 5.0 ms, 11 10 ms; default 00
// - undervoltage, overvoltage, overcurrent watched per regulator while monitoring is active
// - active-low interrupt output asserts for each unmasked fault latch
// - fault configuration returns to defaults on every power up; host reprograms it
// - keep-on bit per regulator and fault type: 0 disables, 1 keeps running
// - overcurrent accepted after 1.0 ms debounce; disabling regulator turns off at once
// - over/undervoltage pass a filter; disable only after 300 us further persistence
// - auto-restore 0 keeps regulator off after fault clears; 1 restores it
// - host toggling enable off then on re-enables a regulator left off
// - auto-restore acts 500 us after fault clears; overcurrent removal debounced 1.0 ms
// - auto-restore decides recovery whatever the hardware enable pin level
// - each protected fault event increments shared tally unless equal to limit; events in the same cycle add only one
// - host reads and resets tally; tally reaching limit starts power down
// - limit loaded from one-time default at power up; limit 0 disables tally shutdown
// - fault starts fault timer; clearing resets it; expiry starts power down
// - timer codes 0..11 give 1..1024, 2056 ms; 12..14 reserved, 15 disables
// - ignore bit per regulator and fault type, 1 bypasses; defaults from one-time bits
// - ignored fault never counts, times, disables regulator or drops power good
// - ignored fault still sets its latch and interrupt unless masked
// - fault latches set on event, readable always, cleared by writing one
package rfp_pkg;
  localparam int NREG = 3;
  localparam int NCH = 9;
  // one bit per regulator for each fault type; uv in [2:0], ov [5:3], oc [8:6]
  typedef struct packed {
    logic [2:0] oc;
    logic [2:0] ov;
    logic [2:0] uv;
  } rfp_fault_t;
  typedef struct packed {
    logic [3:0] tally_limit;
    logic [3:0] timer_sel;
    logic [1:0] holdoff_sel;
  } rfp_otp_t;
  // reference tick
  localparam int CLK_MHZ = 20;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int MS_US = 1000;
  // durations in microseconds, counted in ticks
  localparam int OC_DEBOUNCE_US = 1000;
  localparam int OVUV_FILTER_US = 10;
  localparam int OVUV_PERSIST_US = 300;
  localparam int RESTORE_US = 500;
  localparam int HOLD_1_US = 1500;
  localparam int HOLD_2_US = 5000;
  localparam int HOLD_3_US = 10000;
  localparam int OC_DEBOUNCE_TICKS = OC_DEBOUNCE_US / TICK_US;
  localparam int OVUV_FILTER_TICKS = OVUV_FILTER_US / TICK_US;
  localparam int OVUV_PERSIST_TICKS = OVUV_PERSIST_US / TICK_US;
  localparam int RESTORE_TICKS = RESTORE_US / TICK_US;
  // fault timer
  localparam logic [3:0] TIMER_LAST_CODE = 4'hb;
  localparam logic [11:0] TIMER_TOP_MS = 12'h808;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEEP = 8'h04;
  localparam logic [7:0] ADDR_IGNORE = 8'h08;
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TALLY = 8'h18;
  localparam logic [7:0] ADDR_ENABLE = 8'h1c;
  // field positions
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_TIMER_LSB = 4;
  localparam int CTRL_LIMIT_LSB = 8;
  localparam int KEEP_RESTORE_LSB = 16;
  localparam int STATUS_EN_LSB = 16;
  localparam int STATUS_STATE_LSB = 20;
  // reset values
  localparam logic [1:0] HOLD_RESET = 2'h0;
  localparam logic [3:0] TIMER_RESET = 4'hf;
  localparam logic [3:0] LIMIT_RESET = 4'h0;
  localparam logic [8:0] KEEP_RESET = 9'h000;
  localparam logic [2:0] RESTORE_RESET = 3'h0;
  localparam logic [8:0] IGNORE_RESET = 9'h000;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam logic [2:0] ENABLE_RESET = 3'h0;
endpackage

/* File: sim/rfp_host_model.sv */
// host model: apb master issuing register cycles
`timescale 1ns/1ps
module rfp_host_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  import rfp_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // config, w1c, tally reset, enable toggle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    // released lines show inverted values
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: sim/test_regulator_fault_protection.sv */
// testbench: regulator fault protection
`timescale 1ns/1ps
module test_regulator_fault_protection;
  import rfp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic power_on_input, monitor_active, power_up_start, pd_seq_start, pd_seq_done;
  logic power_on_gated, shutdown_req, irq_out_n;
  logic [2:0] hw_regulator_enable, regulator_en, power_good_out;
  logic [8:0] otp_ignore;
  rfp_fault_t fault_cond;
  rfp_otp_t otp_cfg;
  int err_total = 0;
  int checks_done = 0;
  int sd_count = 0;

  rfp_fault_protect i_rfp_fault_protect (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_on_input(power_on_input),
    .hw_regulator_enable(hw_regulator_enable), .fault_cond(fault_cond),
    .monitor_active(monitor_active), .power_up_start(power_up_start), .otp_cfg(otp_cfg),
    .otp_ignore(otp_ignore), .pd_seq_start(pd_seq_start), .pd_seq_done(pd_seq_done),
    .power_on_gated(power_on_gated), .shutdown_req(shutdown_req),
    .regulator_en(regulator_en), .power_good_out(power_good_out), .irq_out_n(irq_out_n));

  rfp_host_model i_rfp_host_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (shutdown_req === 1'b1) begin
      sd_count <= sd_count + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_rfp_host_model.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    i_rfp_host_model.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_out_n !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq_out_n}, 32'h0);
  endtask

  task automatic t_boot;
    logic [31:0] q;
    logic e;
    rd(ADDR_CTRL, 32'h000000f0);
    i_rfp_host_model.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    @(posedge pclk) power_up_start <= 1'b1;
    @(posedge pclk) power_up_start <= 1'b0;
    rd(ADDR_CTRL, 32'h000002f1);
    rd(ADDR_IGNORE, 32'h0);
    wr(ADDR_CTRL, 32'h00000200);
    wr(ADDR_ENABLE, 32'h7);
    repeat (4) @(posedge pclk);
    chk({26'h0, power_good_out, regulator_en}, 32'h3f);
    chk({31'h0, power_on_gated}, 32'h1);
    $display("boot test done");
  endtask

  task automatic t_ovuv;
    fault_cond[3] <= 1'b1;
    wait_irq(1000);
    rd(ADDR_FLAG, 32'h8);
    rd(ADDR_TALLY, 32'h1);
    repeat (OVUV_PERSIST_TICKS * TICK_CYCLES - 100) @(posedge pclk);
    chk({29'h0, regulator_en}, 32'h7);
    repeat (250) @(posedge pclk);
    chk({29'h0, regulator_en}, 32'h6);
    fault_cond[3] <= 1'b0;
    repeat (10800) @(posedge pclk);
    chk({29'h0, regulator_en}, 32'h6);
    chk(sd_count, 32'h0);
    wr(ADDR_TALLY, 32'h0);
    wr(ADDR_FLAG, 32'h8);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out_n}, 32'h1);
    wr(ADDR_ENABLE, 32'h6);
    wr(ADDR_ENABLE, 32'h7);
    @(posedge pclk);
    chk({29'h0, regulator_en}, 32'h7);
    $display("ov test done");
  endtask

  task automatic t_ignore;
    wr(ADDR_IGNORE, 32'h20);
    fault_cond[5] <= 1'b1;
    wait_irq(1000);
    rd(ADDR_FLAG, 32'h20);
    repeat (6200) @(posedge pclk);
    chk({26'h0, power_good_out, regulator_en}, 32'h3f);
    rd(ADDR_TALLY, 32'h0);
    wr(ADDR_MASK, 32'h20);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out_n}, 32'h1);
    fault_cond[5] <= 1'b0;
    repeat (OVUV_FILTER_TICKS * TICK_CYCLES + 100) @(posedge pclk);
    wr(ADDR_FLAG, 32'h20);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_IGNORE, 32'h0);
    $display("ignore test done");
  endtask

  task automatic t_restore;
    int n;
    int lo;
    lo = (RESTORE_TICKS + OVUV_FILTER_TICKS) * TICK_CYCLES;
    wr(ADDR_KEEP, 32'h00020000);
    wr(ADDR_ENABLE, 32'h5);
    hw_regulator_enable <= 3'h2;
    fault_cond[1] <= 1'b1;
    wait_irq(1000);
    repeat (OVUV_PERSIST_TICKS * TICK_CYCLES + 150) @(posedge pclk);
    chk({29'h0, regulator_en}, 32'h5);
    fault_cond[1] <= 1'b0;
    n = 0;
    while (regulator_en[1] !== 1'b1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= lo - 100 && n <= lo + 200}, 32'h1);
    wr(ADDR_TALLY, 32'h0);
    wr(ADDR_FLAG, 32'h2);
    wr(ADDR_ENABLE, 32'h7);
    hw_regulator_enable <= 3'h0;
    $display("restore test done");
  endtask

  task automatic t_shutdown;
    int n;
    int lo;
    lo = HOLD_1_US * TICK_CYCLES;
    wr(ADDR_CTRL, 32'h000001f0);
    wr(ADDR_KEEP, 32'h0);
    fault_cond[8] <= 1'b1;
    wait_irq(OC_DEBOUNCE_TICKS * TICK_CYCLES + 500);
    chk({29'h0, regulator_en}, 32'h3);
    repeat (3) @(posedge pclk);
    chk(sd_count, 32'h1);
    rd(ADDR_TALLY, 32'h1);
    @(posedge pclk) pd_seq_start <= 1'b1;
    @(posedge pclk) pd_seq_start <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, power_on_gated}, 32'h0);
    fault_cond[8] <= 1'b0;
    @(posedge pclk) pd_seq_done <= 1'b1;
    @(posedge pclk) pd_seq_done <= 1'b0;
    n = 0;
    while (power_on_gated !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= lo - 50 && n <= lo + 100}, 32'h1);
    $display("shutdown test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (99000) @(posedge pclk);
    err_total++;
    wrap_up;
  end

  initial begin
    presetn = 1'b0;
    power_on_input = 1'b1;
    monitor_active = 1'b1;
    power_up_start = 1'b0;
    pd_seq_start = 1'b0;
    pd_seq_done = 1'b0;
    hw_regulator_enable = 3'h0;
    fault_cond = '0;
    otp_cfg = '{tally_limit: 4'h2, timer_sel: 4'hf, holdoff_sel: 2'h1};
    otp_ignore = 9'h000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_boot;
    t_ovuv;
    t_ignore;
    t_restore;
    t_shutdown;
    wrap_up;
  end
endmodule
